// *** pkg/cache_ctrl_pkg.sv ***
/*
 Constants, register layout and controller states for the split cache
 controller. Assumes a 32-bit byte address and 128-bit cache lines.
*/
package cache_ctrl_pkg;

	// register map
	localparam logic [31:0] CACHE_CONTROL_ADDR = 32'hFFFF_FFFC;

	// cache_control fields, little-endian positions of b24..b31
	localparam int MODE_CHANGE_MASK_BIT = 7;
	localparam int ICACHE_INVALIDATE_BIT = 6;
	localparam int DCACHE_INVALIDATE_BIT = 5;
	localparam int DCACHE_COPYBACK_BIT = 4;
	localparam int ICACHE_ON_BIT = 1;
	localparam int DCACHE_ON_BIT = 0;

	// reset values
	localparam logic ICACHE_ON_RST = 1'b0;
	localparam logic DCACHE_ON_RST = 1'b0;
	localparam logic IINV_PEND_RST = 1'b1;
	localparam logic DINV_PEND_RST = 1'b1;
	localparam logic COPYBACK_PEND_RST = 1'b0;

	// address windows
	localparam logic [31:0] CACHEABLE_TOP = 32'h1FFF_FFFF;
	localparam logic [31:0] SPECIAL_WINDOW_LO = 32'h00E0_0000;
	localparam logic [31:0] SPECIAL_WINDOW_HI = 32'h00EF_FFFF;

	// address split: b20..b27 are bits 11..4
	localparam int IDX_LSB = 4;
	localparam int IDX_MSB = 11;
	localparam int TAG_LSB = 12;
	localparam int WORD_LSB = 2;
	localparam int WORD_MSB = 3;
	localparam logic [7:0] LAST_SET = 8'hFF;
	localparam logic [1:0] LAST_BEAT = 2'h3;

	typedef enum logic [3:0] {
		S_IDLE,
		S_IINV,
		S_DINV,
		S_CB_SCAN,
		S_WB,
		S_IFILL,
		S_DFILL,
		S_IUNC,
		S_DRD,
		S_DWR
	} state_t;

endpackage

// *** verilog/cache_array.sv ***
/*
 Two-way set storage: tags, valid, dirty, LRU and 128-bit line data in
 flip-flops. Assumes one index shared by reads and writes, same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module cache_array #(
	parameter int SETS = 256,
	parameter int IDX_W = 8,
	parameter int TAG_W = 20
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// set select and way
	input wire logic [IDX_W-1:0] i_idx,
	input wire logic i_way,
	// writes
	input wire logic i_tag_we,
	input wire logic [TAG_W-1:0] i_tag,
	input wire logic i_word_we,
	input wire logic [1:0] i_word_sel,
	input wire logic [31:0] i_word,
	input wire logic i_dirty_we,
	input wire logic i_dirty_val,
	input wire logic i_inv_set,
	input wire logic i_lru_we,
	// set contents
	output logic [1:0][TAG_W-1:0] o_tag,
	output logic [1:0] o_valid,
	output logic [1:0] o_dirty,
	output logic o_lru,
	output logic [1:0][127:0] o_data
);
	logic [1:0][TAG_W-1:0] tag_mem [SETS];
	logic [1:0][127:0] data_mem [SETS];
	logic [1:0] valid [SETS];
	logic [1:0] dirty [SETS];
	logic [SETS-1:0] lru;

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			for (int s = 0; s < SETS; s++) begin
				valid[s] <= 2'h0;
			end
		end else if (i_inv_set) begin
			valid[i_idx] <= 2'h0;
		end else if (i_tag_we) begin
			valid[i_idx][i_way] <= 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			for (int s = 0; s < SETS; s++) begin
				dirty[s] <= 2'h0;
			end
		end else if (i_tag_we) begin
			dirty[i_idx][i_way] <= 1'b0;
		end else if (i_dirty_we) begin
			dirty[i_idx][i_way] <= i_dirty_val;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			lru <= '0;
		end else if (i_lru_we) begin
			lru[i_idx] <= ~i_way;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_tag_we) begin
			tag_mem[i_idx][i_way] <= i_tag;
		end
		if (i_word_we) begin
			data_mem[i_idx][i_way][{i_word_sel, 5'h00} +: 32] <= i_word;
		end
	end

	assign o_tag = tag_mem[i_idx];
	assign o_valid = valid[i_idx];
	assign o_dirty = dirty[i_idx];
	assign o_lru = lru[i_idx];
	assign o_data = data_mem[i_idx];
endmodule
`default_nettype wire

// *** verilog/split_cache_control.sv ***
/*
 Split instruction/data cache controller with its control register.
 Assumes CPU, memory and attribute inputs on the same clock, a held
 request until its one-cycle ack, and one memory word per mem ack.
*/
`timescale 1ns/100ps
`default_nettype none
module split_cache_control #(
	parameter int SETS = 256
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// register port
	input wire logic [31:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_we,
	input wire logic i_reg_re,
	output logic [31:0] o_reg_rdata,
	// cacheability settings
	input wire logic i_xlat_on,
	input wire logic i_sram_icache,
	input wire logic [7:0] i_area_icache,
	input wire logic i_sram_dcache,
	input wire logic [7:0] i_area_dcache,
	// instruction fetch port
	input wire logic i_if_req,
	input wire logic [31:0] i_if_addr,
	input wire logic i_if_page_cache,
	input wire logic i_if_sram,
	input wire logic [2:0] i_if_block,
	output logic o_if_ack,
	output logic [31:0] o_if_rdata,
	// data port
	input wire logic i_d_req,
	input wire logic i_d_we,
	input wire logic [31:0] i_d_addr,
	input wire logic [31:0] i_d_wdata,
	input wire logic i_d_page_cache,
	input wire logic i_d_sram,
	input wire logic [2:0] i_d_block,
	output logic o_d_ack,
	output logic [31:0] o_d_rdata,
	// memory port
	output logic o_mem_req,
	output logic o_mem_we,
	output logic [31:0] o_mem_addr,
	output logic [31:0] o_mem_wdata,
	input wire logic i_mem_ack,
	input wire logic [31:0] i_mem_rdata
);
	localparam int IDX_W = cache_ctrl_pkg::IDX_MSB - cache_ctrl_pkg::IDX_LSB + 1;
	localparam int TAG_W = 32 - cache_ctrl_pkg::TAG_LSB;

	cache_ctrl_pkg::state_t state;
	logic icache_on;
	logic dcache_on;
	logic pend_iinv;
	logic pend_dinv;
	logic pend_cb;
	logic [IDX_W-1:0] scan;
	logic way;
	logic wb_fill;
	logic [1:0] beat;
	logic [1:0] cnt;
	logic [31:0] cur_addr;
	logic [31:0] cur_wdata;

	logic reg_hit;
	logic reg_wr;
	logic maint;
	logic take_d;
	logic take_i;
	logic start_cb;
	logic start_dinv;
	logic start_iinv;
	logic iinv_busy;
	logic if_cacheable;
	logic d_cacheable;
	logic if_special;
	logic d_special;

	// instruction array view
	logic [IDX_W-1:0] ic_idx;
	logic ic_way;
	logic ic_tag_we;
	logic ic_word_we;
	logic ic_lru_we;
	logic [1:0][TAG_W-1:0] ic_tag;
	logic [1:0] ic_valid;
	logic ic_lru;
	logic [1:0][127:0] ic_data;
	logic [1:0] ic_hit;
	logic ic_vict;

	// data array view
	logic [IDX_W-1:0] dc_idx;
	logic dc_way;
	logic dc_tag_we;
	logic dc_word_we;
	logic [1:0] dc_word_sel;
	logic [31:0] dc_word;
	logic dc_dirty_we;
	logic dc_lru_we;
	logic [1:0][TAG_W-1:0] dc_tag;
	logic [1:0] dc_valid;
	logic [1:0] dc_dirty;
	logic dc_lru;
	logic [1:0][127:0] dc_data;
	logic [1:0] dc_hit;
	logic dc_vict;
	logic dc_wr_hit;

	// register access
	assign reg_hit = i_reg_addr == cache_ctrl_pkg::CACHE_CONTROL_ADDR;
	assign reg_wr = i_reg_we && reg_hit;
	assign iinv_busy = pend_iinv || state == cache_ctrl_pkg::S_IINV;

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			icache_on <= cache_ctrl_pkg::ICACHE_ON_RST;
			dcache_on <= cache_ctrl_pkg::DCACHE_ON_RST;
		end else if (reg_wr && !i_reg_wdata[cache_ctrl_pkg::MODE_CHANGE_MASK_BIT]) begin
			icache_on <= i_reg_wdata[cache_ctrl_pkg::ICACHE_ON_BIT];
			dcache_on <= i_reg_wdata[cache_ctrl_pkg::DCACHE_ON_BIT];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_reg_rdata <= 32'h0000_0000;
		end else if (i_reg_re && reg_hit) begin
			o_reg_rdata <= 32'h0000_0000;
			o_reg_rdata[cache_ctrl_pkg::ICACHE_INVALIDATE_BIT] <= iinv_busy;
			o_reg_rdata[cache_ctrl_pkg::ICACHE_ON_BIT] <= icache_on;
			o_reg_rdata[cache_ctrl_pkg::DCACHE_ON_BIT] <= dcache_on;
		end else begin
			o_reg_rdata <= 32'h0000_0000;
		end
	end

	// pending maintenance, the start wins over a new request
	assign maint = pend_cb || pend_dinv || pend_iinv;
	assign start_cb = state == cache_ctrl_pkg::S_IDLE && pend_cb;
	assign start_dinv = state == cache_ctrl_pkg::S_IDLE && !pend_cb && pend_dinv;
	assign start_iinv = state == cache_ctrl_pkg::S_IDLE && !pend_cb && !pend_dinv && pend_iinv;

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			pend_iinv <= cache_ctrl_pkg::IINV_PEND_RST;
			pend_dinv <= cache_ctrl_pkg::DINV_PEND_RST;
			pend_cb <= cache_ctrl_pkg::COPYBACK_PEND_RST;
		end else begin
			pend_iinv <= (pend_iinv && !start_iinv) ||
				(reg_wr && i_reg_wdata[cache_ctrl_pkg::ICACHE_INVALIDATE_BIT]);
			pend_dinv <= (pend_dinv && !start_dinv) ||
				(reg_wr && i_reg_wdata[cache_ctrl_pkg::DCACHE_INVALIDATE_BIT]);
			pend_cb <= (pend_cb && !start_cb) ||
				(reg_wr && i_reg_wdata[cache_ctrl_pkg::DCACHE_COPYBACK_BIT]);
		end
	end

	// cacheability decode
	assign if_special = i_if_addr >= cache_ctrl_pkg::SPECIAL_WINDOW_LO &&
		i_if_addr <= cache_ctrl_pkg::SPECIAL_WINDOW_HI;
	assign d_special = i_d_addr >= cache_ctrl_pkg::SPECIAL_WINDOW_LO &&
		i_d_addr <= cache_ctrl_pkg::SPECIAL_WINDOW_HI;
	assign if_cacheable = icache_on &&
		i_if_addr <= cache_ctrl_pkg::CACHEABLE_TOP &&
		!if_special &&
		(i_xlat_on ? i_if_page_cache :
		(i_if_sram ? i_sram_icache : i_area_icache[i_if_block]));
	assign d_cacheable = dcache_on &&
		i_d_addr <= cache_ctrl_pkg::CACHEABLE_TOP &&
		!d_special &&
		(i_xlat_on ? i_d_page_cache :
		(i_d_sram ? i_sram_dcache : i_area_dcache[i_d_block]));

	// lookup, victim by LRU when both ways valid
	assign ic_idx = state == cache_ctrl_pkg::S_IDLE ?
		i_if_addr[cache_ctrl_pkg::IDX_MSB:cache_ctrl_pkg::IDX_LSB] : scan;
	assign dc_idx = state == cache_ctrl_pkg::S_IDLE ?
		i_d_addr[cache_ctrl_pkg::IDX_MSB:cache_ctrl_pkg::IDX_LSB] : scan;
	assign ic_hit[0] = ic_valid[0] && ic_tag[0] == i_if_addr[31:cache_ctrl_pkg::TAG_LSB];
	assign ic_hit[1] = ic_valid[1] && ic_tag[1] == i_if_addr[31:cache_ctrl_pkg::TAG_LSB];
	assign dc_hit[0] = dc_valid[0] && dc_tag[0] == i_d_addr[31:cache_ctrl_pkg::TAG_LSB];
	assign dc_hit[1] = dc_valid[1] && dc_tag[1] == i_d_addr[31:cache_ctrl_pkg::TAG_LSB];
	assign ic_vict = !ic_valid[0] ? 1'b0 : (!ic_valid[1] ? 1'b1 : ic_lru);
	assign dc_vict = !dc_valid[0] ? 1'b0 : (!dc_valid[1] ? 1'b1 : dc_lru);

	// request acceptance, maintenance first
	assign take_d = state == cache_ctrl_pkg::S_IDLE && !maint && i_d_req && !o_d_ack;
	assign take_i = state == cache_ctrl_pkg::S_IDLE && !maint && !take_d &&
		i_if_req && !o_if_ack;
	assign dc_wr_hit = take_d && i_d_we && d_cacheable && |dc_hit;

	// array write controls
	assign ic_way = state == cache_ctrl_pkg::S_IDLE ? ic_hit[1] : way;
	assign ic_word_we = state == cache_ctrl_pkg::S_IFILL && i_mem_ack;
	assign ic_tag_we = ic_word_we && cnt == cache_ctrl_pkg::LAST_BEAT;
	assign ic_lru_we = (take_i && if_cacheable && |ic_hit) || ic_tag_we;
	assign dc_way = state == cache_ctrl_pkg::S_IDLE ? dc_hit[1] : way;
	assign dc_word_we = (state == cache_ctrl_pkg::S_DFILL && i_mem_ack) || dc_wr_hit;
	assign dc_word = state == cache_ctrl_pkg::S_IDLE ? i_d_wdata : i_mem_rdata;
	assign dc_word_sel = state == cache_ctrl_pkg::S_IDLE ?
		i_d_addr[cache_ctrl_pkg::WORD_MSB:cache_ctrl_pkg::WORD_LSB] : beat;
	assign dc_tag_we = state == cache_ctrl_pkg::S_DFILL && i_mem_ack &&
		cnt == cache_ctrl_pkg::LAST_BEAT;
	assign dc_dirty_we = dc_wr_hit || (state == cache_ctrl_pkg::S_WB && i_mem_ack &&
		cnt == cache_ctrl_pkg::LAST_BEAT && !wb_fill);
	assign dc_lru_we = (take_d && d_cacheable && |dc_hit) || dc_tag_we;

	cache_array #(
		.SETS(SETS),
		.IDX_W(IDX_W),
		.TAG_W(TAG_W)
	) icache (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_idx(ic_idx),
		.i_way(ic_way),
		.i_tag_we(ic_tag_we),
		.i_tag(cur_addr[31:cache_ctrl_pkg::TAG_LSB]),
		.i_word_we(ic_word_we),
		.i_word_sel(beat),
		.i_word(i_mem_rdata),
		.i_dirty_we(1'b0),
		.i_dirty_val(1'b0),
		.i_inv_set(state == cache_ctrl_pkg::S_IINV),
		.i_lru_we(ic_lru_we),
		.o_tag(ic_tag),
		.o_valid(ic_valid),
		.o_dirty(),
		.o_lru(ic_lru),
		.o_data(ic_data)
	);

	cache_array #(
		.SETS(SETS),
		.IDX_W(IDX_W),
		.TAG_W(TAG_W)
	) dcache (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_idx(dc_idx),
		.i_way(dc_way),
		.i_tag_we(dc_tag_we),
		.i_tag(cur_addr[31:cache_ctrl_pkg::TAG_LSB]),
		.i_word_we(dc_word_we),
		.i_word_sel(dc_word_sel),
		.i_word(dc_word),
		.i_dirty_we(dc_dirty_we),
		.i_dirty_val(state == cache_ctrl_pkg::S_IDLE),
		.i_inv_set(state == cache_ctrl_pkg::S_DINV),
		.i_lru_we(dc_lru_we),
		.o_tag(dc_tag),
		.o_valid(dc_valid),
		.o_dirty(dc_dirty),
		.o_lru(dc_lru),
		.o_data(dc_data)
	);

	// memory port, one word per ack
	always_comb begin
		o_mem_req = 1'b0;
		o_mem_we = 1'b0;
		o_mem_addr = cur_addr;
		o_mem_wdata = cur_wdata;
		unique case (state)
			cache_ctrl_pkg::S_WB: begin
				o_mem_req = 1'b1;
				o_mem_we = 1'b1;
				o_mem_addr = {dc_tag[way], scan, beat, 2'h0};
				o_mem_wdata = dc_data[way][{beat, 5'h00} +: 32];
			end
			cache_ctrl_pkg::S_IFILL, cache_ctrl_pkg::S_DFILL: begin
				o_mem_req = 1'b1;
				o_mem_addr = {cur_addr[31:cache_ctrl_pkg::IDX_LSB], beat, 2'h0};
			end
			cache_ctrl_pkg::S_IUNC, cache_ctrl_pkg::S_DRD: begin
				o_mem_req = 1'b1;
			end
			cache_ctrl_pkg::S_DWR: begin
				o_mem_req = 1'b1;
				o_mem_we = 1'b1;
			end
			cache_ctrl_pkg::S_IDLE, cache_ctrl_pkg::S_IINV,
			cache_ctrl_pkg::S_DINV, cache_ctrl_pkg::S_CB_SCAN: begin
			end
		endcase
	end

	// controller
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			state <= cache_ctrl_pkg::S_IDLE;
			scan <= '0;
			way <= 1'b0;
			wb_fill <= 1'b0;
			beat <= 2'h0;
			cnt <= 2'h0;
			cur_addr <= 32'h0000_0000;
			cur_wdata <= 32'h0000_0000;
			o_if_ack <= 1'b0;
			o_if_rdata <= 32'h0000_0000;
			o_d_ack <= 1'b0;
			o_d_rdata <= 32'h0000_0000;
		end else begin
			o_if_ack <= 1'b0;
			o_d_ack <= 1'b0;
			unique case (state)
				cache_ctrl_pkg::S_IDLE: begin
					if (start_cb) begin
						state <= cache_ctrl_pkg::S_CB_SCAN;
						scan <= '0;
						way <= 1'b0;
					end else if (start_dinv) begin
						state <= cache_ctrl_pkg::S_DINV;
						scan <= '0;
					end else if (start_iinv) begin
						state <= cache_ctrl_pkg::S_IINV;
						scan <= '0;
					end else if (take_d) begin
						cur_addr <= i_d_addr;
						cur_wdata <= i_d_wdata;
						scan <= i_d_addr[cache_ctrl_pkg::IDX_MSB:cache_ctrl_pkg::IDX_LSB];
						beat <= i_d_addr[cache_ctrl_pkg::WORD_MSB:cache_ctrl_pkg::WORD_LSB];
						cnt <= 2'h0;
						if (d_cacheable && |dc_hit) begin
							o_d_ack <= 1'b1;
							o_d_rdata <= dc_data[dc_hit[1]][{i_d_addr[3:2], 5'h00} +: 32];
						end else if (i_d_we) begin
							state <= cache_ctrl_pkg::S_DWR;
						end else if (d_cacheable) begin
							way <= dc_vict;
							if (dc_valid[dc_vict] && dc_dirty[dc_vict]) begin
								state <= cache_ctrl_pkg::S_WB;
								wb_fill <= 1'b1;
								beat <= 2'h0;
							end else begin
								state <= cache_ctrl_pkg::S_DFILL;
							end
						end else begin
							state <= cache_ctrl_pkg::S_DRD;
						end
					end else if (take_i) begin
						cur_addr <= i_if_addr;
						scan <= i_if_addr[cache_ctrl_pkg::IDX_MSB:cache_ctrl_pkg::IDX_LSB];
						beat <= i_if_addr[cache_ctrl_pkg::WORD_MSB:cache_ctrl_pkg::WORD_LSB];
						cnt <= 2'h0;
						if (if_cacheable && |ic_hit) begin
							o_if_ack <= 1'b1;
							o_if_rdata <= ic_data[ic_hit[1]][{i_if_addr[3:2], 5'h00} +: 32];
						end else if (if_cacheable) begin
							way <= ic_vict;
							state <= cache_ctrl_pkg::S_IFILL;
						end else begin
							state <= cache_ctrl_pkg::S_IUNC;
						end
					end
				end
				cache_ctrl_pkg::S_IINV, cache_ctrl_pkg::S_DINV: begin
					scan <= scan + 1'b1;
					if (scan == cache_ctrl_pkg::LAST_SET) begin
						state <= cache_ctrl_pkg::S_IDLE;
					end
				end
				cache_ctrl_pkg::S_CB_SCAN: begin
					if (dc_valid[way] && dc_dirty[way]) begin
						state <= cache_ctrl_pkg::S_WB;
						wb_fill <= 1'b0;
						beat <= 2'h0;
						cnt <= 2'h0;
					end else begin
						way <= ~way;
						if (way) begin
							scan <= scan + 1'b1;
						end
						if (way && scan == cache_ctrl_pkg::LAST_SET) begin
							state <= cache_ctrl_pkg::S_IDLE;
						end
					end
				end
				cache_ctrl_pkg::S_WB: begin
					if (i_mem_ack) begin
						beat <= beat + 1'b1;
						cnt <= cnt + 1'b1;
						if (cnt == cache_ctrl_pkg::LAST_BEAT) begin
							if (wb_fill) begin
								state <= cache_ctrl_pkg::S_DFILL;
								beat <= cur_addr[cache_ctrl_pkg::WORD_MSB:cache_ctrl_pkg::WORD_LSB];
								cnt <= 2'h0;
							end else begin
								state <= cache_ctrl_pkg::S_CB_SCAN;
							end
						end
					end
				end
				cache_ctrl_pkg::S_IFILL: begin
					if (i_mem_ack) begin
						beat <= beat + 1'b1;
						cnt <= cnt + 1'b1;
						if (cnt == 2'h0) begin
							o_if_ack <= 1'b1;
							o_if_rdata <= i_mem_rdata;
						end
						if (cnt == cache_ctrl_pkg::LAST_BEAT) begin
							state <= cache_ctrl_pkg::S_IDLE;
						end
					end
				end
				cache_ctrl_pkg::S_DFILL: begin
					if (i_mem_ack) begin
						beat <= beat + 1'b1;
						cnt <= cnt + 1'b1;
						if (cnt == 2'h0) begin
							o_d_ack <= 1'b1;
							o_d_rdata <= i_mem_rdata;
						end
						if (cnt == cache_ctrl_pkg::LAST_BEAT) begin
							state <= cache_ctrl_pkg::S_IDLE;
						end
					end
				end
				cache_ctrl_pkg::S_IUNC: begin
					if (i_mem_ack) begin
						o_if_ack <= 1'b1;
						o_if_rdata <= i_mem_rdata;
						state <= cache_ctrl_pkg::S_IDLE;
					end
				end
				cache_ctrl_pkg::S_DRD: begin
					if (i_mem_ack) begin
						o_d_ack <= 1'b1;
						o_d_rdata <= i_mem_rdata;
						state <= cache_ctrl_pkg::S_IDLE;
					end
				end
				cache_ctrl_pkg::S_DWR: begin
					if (i_mem_ack) begin
						o_d_ack <= 1'b1;
						state <= cache_ctrl_pkg::S_IDLE;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// *** test/mem_model.sv ***
/*
 External memory model for the cache controller bench.
 Assumes a request held until its one-cycle ack, one word per ack.
*/
`timescale 1ns/100ps
`default_nettype none
module mem_model (
	// clock and request
	input wire logic i_clk,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic [1:0] i_lat,
	// answer
	output logic o_ack,
	output logic [31:0] o_rdata
);
	logic [31:0] mem [logic [31:0]];
	int n_tx = 0;
	int n_wait = 0;
	function automatic logic [31:0] rd(input logic [31:0] a);
		return mem.exists(a) ? mem[a] : a ^ 32'h5A5A_0000;
	endfunction
	initial begin
		o_ack = 1'b0;
		o_rdata = 32'h0;
	end
	// read data outside an ack keeps moving
	always @(posedge i_clk) begin
		o_ack <= 1'b0;
		o_rdata <= ~o_rdata;
		if (i_req && !o_ack) begin
			if (n_wait >= i_lat) begin
				o_ack <= 1'b1;
				n_wait = 0;
				n_tx++;
				if (i_we)
					mem[i_addr] = i_wdata;
				else
					o_rdata <= rd(i_addr);
			end else
				n_wait++;
		end
	end
endmodule
`default_nettype wire

// *** test/split_cache_control_props.sv ***
/*
 Port checker for the split cache controller.
 Assumes the controller's top ports and its package.
*/
`timescale 1ns/100ps
`default_nettype none
module split_cache_control_props (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// register port
	input wire logic [31:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_we,
	input wire logic i_reg_re,
	input wire logic [31:0] o_reg_rdata,
	// cpu ports
	input wire logic [31:0] i_if_addr,
	input wire logic o_if_ack,
	input wire logic i_d_we,
	input wire logic [31:0] i_d_addr,
	input wire logic o_d_ack,
	// memory port
	input wire logic o_mem_req,
	input wire logic o_mem_we,
	input wire logic [31:0] o_mem_addr,
	input wire logic [31:0] o_mem_wdata,
	input wire logic i_mem_ack
);
	logic hit;
	logic [1:0] mode_q;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	assign hit = i_reg_addr == cache_ctrl_pkg::CACHE_CONTROL_ADDR;
	// modes last loaded by software
	always_ff @(posedge i_clk) begin
		if (!i_rst_b)
			mode_q <= 2'h0;
		else if (i_reg_we && hit && !i_reg_wdata[7])
			mode_q <= i_reg_wdata[1:0];
	end
	reserved_zero_a: assert property (o_reg_rdata[31:7] == 25'h0 && o_reg_rdata[5:2] == 4'h0)
		else $error("action bits read nonzero");
	iinv_busy_a: assert property (i_reg_we && hit && i_reg_wdata[6] ##1 i_reg_re && hit
		|=> o_reg_rdata[6]) else $error("invalidate status not set");
	mode_load_a: assert property (i_reg_we && hit && !i_reg_wdata[7] ##1 i_reg_re && hit
		|=> o_reg_rdata[1:0] == $past(i_reg_wdata[1:0], 2)) else $error("modes not loaded");
	mode_mask_a: assert property (i_reg_we && hit && i_reg_wdata[7] ##1 i_reg_re && hit
		|=> o_reg_rdata[1:0] == mode_q) else $error("masked write changed modes");
	window_direct_a: assert property (o_d_ack && !i_d_we && i_d_addr[31:20] == 12'h00E
		|-> $past(i_mem_ack && !o_mem_we) && $past(o_mem_addr) == i_d_addr)
		else $error("window read not from memory");
	high_direct_a: assert property (o_if_ack && i_if_addr[31:29] != 3'h0
		|-> $past(i_mem_ack && !o_mem_we) && $past(o_mem_addr) == i_if_addr)
		else $error("high fetch not from memory");
	mem_hold_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr)
		&& $stable(o_mem_we) && $stable(o_mem_wdata)) else $error("memory request dropped");
	ack_gap_a: assert property (o_d_ack |=> !o_d_ack)
		else $error("data ack longer than one cycle");
endmodule
bind split_cache_control split_cache_control_props props_i (.*);
`default_nettype wire

// *** test/split_cache_control_tb.sv ***
/*
 Self-checking bench for the split cache controller.
 Assumes the memory model on the memory port and a 50 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module split_cache_control_tb;
	localparam logic [31:0] CA = cache_ctrl_pkg::CACHE_CONTROL_ADDR;
	logic i_clk, i_rst_b, i_reg_we, i_reg_re, i_xlat_on, i_sram_icache, i_sram_dcache;
	logic i_if_req, i_if_page_cache, i_if_sram, o_if_ack, i_d_req, i_d_we, i_d_page_cache;
	logic i_d_sram, o_d_ack, o_mem_req, o_mem_we, i_mem_ack;
	logic [7:0] i_area_icache, i_area_dcache;
	logic [2:0] i_if_block, i_d_block;
	logic [1:0] mem_lat;
	logic [31:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_if_addr, o_if_rdata, i_d_addr;
	logic [31:0] i_d_wdata, o_d_rdata, o_mem_addr, o_mem_wdata, i_mem_rdata, a, r;
	logic [31:0] ref_mem [logic [31:0]];
	int mismatches = 0;
	int n_compared = 0;
	int waited;
	split_cache_control uut (.*);
	mem_model pm (.i_clk(i_clk), .i_req(o_mem_req), .i_we(o_mem_we), .i_addr(o_mem_addr),
		.i_wdata(o_mem_wdata), .i_lat(mem_lat), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
	function automatic logic [31:0] refv(input logic [31:0] x);
		return ref_mem.exists(x) ? ref_mem[x] : x ^ 32'h5A5A_0000;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("compared=%0d mismatches=%0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic rw(input logic [31:0] ad, input logic [31:0] d);
		i_reg_addr <= ad;
		i_reg_wdata <= d;
		i_reg_we <= 1'b1;
		@(posedge i_clk);
		i_reg_we <= 1'b0;
	endtask
	task automatic rr(input logic [31:0] ad, output logic [31:0] d);
		i_reg_addr <= ad;
		i_reg_re <= 1'b1;
		@(posedge i_clk);
		i_reg_re <= 1'b0;
		@(negedge i_clk) d = o_reg_rdata;
		@(posedge i_clk);
	endtask
	// one cpu access; ntx below zero skips the memory count
	task automatic acc(input logic f, input logic w, input logic [31:0] ad, input int ntx);
		logic [31:0] d;
		logic [31:0] got;
		int t0;
		d = $urandom;
		t0 = pm.n_tx;
		mem_lat <= 2'($urandom);
		if (f) begin
			i_if_req <= 1'b1;
			i_if_addr <= ad;
			i_if_block <= 3'($urandom);
		end else begin
			i_d_req <= 1'b1;
			i_d_we <= w;
			i_d_addr <= ad;
			i_d_wdata <= d;
			i_d_block <= 3'($urandom);
		end
		waited = 0;
		do begin
			@(posedge i_clk);
			waited++;
		end while ((f ? o_if_ack : o_d_ack) !== 1'b1 && waited < 3000);
		if (waited >= 3000) begin
			mismatches++;
			summarize;
		end
		got = f ? o_if_rdata : o_d_rdata;
		i_if_req <= 1'b0;
		i_d_req <= 1'b0;
		if (w)
			ref_mem[ad] = d;
		else
			chk(got, refv(ad));
		do @(posedge i_clk); while (o_mem_req === 1'b1);
		if (ntx >= 0)
			chk(32'(pm.n_tx - t0), 32'(ntx));
	endtask
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	initial begin
		repeat (30000) @(posedge i_clk);
		mismatches++;
		summarize;
	end
	initial begin
		void'($urandom(54573));
		{i_rst_b, i_reg_we, i_reg_re, i_xlat_on, i_if_req, i_if_sram, i_d_req, i_d_we} = '0;
		{i_d_sram, i_reg_addr, i_reg_wdata, i_if_addr, i_d_addr, i_d_wdata} = '0;
		{i_if_block, i_d_block, mem_lat} = '0;
		{i_sram_icache, i_sram_dcache, i_if_page_cache, i_d_page_cache} = 4'hF;
		{i_area_icache, i_area_dcache} = 16'hFFFF;
		repeat (6) @(posedge i_clk);
		i_rst_b <= 1'b1;
		rr(CA, r);
		chk(r, 32'h0000_0040);
		rw(CA, 32'h0000_0073);
		rr(CA, r);
		chk(r, 32'h0000_0043);
		a = $urandom & 32'h0FFF_FFF0 | 32'h0100_0000;
		acc(0, 0, a + 8, 4);
		acc(0, 0, a, 0);
		acc(0, 1, a, 0);
		chk({31'h0, pm.rd(a) !== ref_mem[a]}, 32'h1);
		acc(0, 1, a + 32'h40, 1);
		acc(0, 0, a + 32'h40, 4);
		acc(0, 0, a + 32'h1000, 4);
		acc(0, 0, a, 0);
		acc(0, 0, a + 32'h2000, 4);
		acc(0, 0, a + 32'h1000, 8);
		chk(pm.rd(a), ref_mem[a]);
		acc(0, 1, a + 32'h2000, 0);
		rw(CA, 32'h0000_0090);
		rr(CA, r);
		chk(r, 32'h0000_0003);
		acc(0, 0, a + 32'h2000, -1);
		chk(pm.rd(a + 32'h2000), ref_mem[a + 32'h2000]);
		acc(0, 1, a + 32'h1000, 0);
		rw(CA, 32'h0000_00B0);
		acc(0, 0, a + 32'h1000, -1);
		chk(32'(waited > 255), 32'h1);
		chk(pm.rd(a + 32'h1000), ref_mem[a + 32'h1000]);
		acc(0, 0, a + 32'h2000, 4);
		acc(1, 0, a + 32'h80, 4);
		acc(1, 0, a + 32'h88, 0);
		rw(CA, 32'h0000_00C0);
		acc(1, 0, a + 32'h80, 4);
		chk(32'(waited > 255), 32'h1);
		for (int i = 0; i < 2; i++) begin
			acc(0, 0, 32'h00E0_0010, 1);
			acc(1, 0, 32'h2000_0040, 1);
		end
		i_xlat_on <= 1'b1;
		i_d_page_cache <= 1'b0;
		acc(0, 0, a + 32'h300, 1);
		i_d_page_cache <= 1'b1;
		acc(0, 0, a + 32'h300, 4);
		i_xlat_on <= 1'b0;
		i_area_dcache <= 8'h00;
		acc(0, 0, a + 32'h400, 1);
		i_d_sram <= 1'b1;
		acc(0, 0, a + 32'h400, 4);
		i_d_sram <= 1'b0;
		i_area_dcache <= 8'hFF;
		rw(CA, 32'h0000_0072);
		rr(CA, r);
		chk(r, 32'h0000_0042);
		acc(0, 0, a + 4, 1);
		acc(0, 0, a + 4, 1);
		rw(CA - 4, 32'h0000_0003);
		rr(CA - 4, r);
		chk(r, 32'h0);
		rr(CA, r);
		chk(r, 32'h0000_0002);
		summarize;
	end
endmodule
`default_nettype wire
